// file: common/irsp_pkg.sv
/*
  Shared constants and types for the two-wire register slave port and its
  bus master end. Assumes a single 250 MHz clock on both ends.
*/
`default_nettype none

package irsp_pkg;

  // ----------------------------------------------------------------------
  // clock and bus rates
  // ----------------------------------------------------------------------
  localparam int MCLK_HZ = 250_000_000;
  localparam int SCL_STD_HZ = 100_000;
  localparam int SCL_FAST_HZ = 400_000;
  // quarter bit periods round up so the bus never runs above its rate
  localparam int QTR_STD_CYCLES = (MCLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
  localparam int QTR_FAST_CYCLES = (MCLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);
  localparam int QTR_W = 10;

  // ----------------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------------
  localparam logic [5:0] ADDR_HI = 6'h34;
  localparam logic [7:0] WRAP_ADDR = 8'h0F;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [15:0] WRITABLE_MAP = 16'hF603;
  localparam logic [15:0] EEPROM_MAP = 16'hB602;

  // ----------------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------------
  localparam int EE_WRITE_MS = 5;
  localparam int EE_WRITE_CYCLES = EE_WRITE_MS * (MCLK_HZ / 1000);
  localparam logic LINE_IDLE = 1'b1;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    OP_WRITE,
    OP_READ_CUR,
    OP_READ_RAND
  } irsp_op_t;

endpackage : irsp_pkg

`default_nettype wire

// file: common/irsp_link_if.sv
/*
  Two-wire link joining the slave port and the bus master end.
  Both lines are open drain with a pull-up; the level is resolved here.
*/
`default_nettype none

interface irsp_link_if;
  logic scl;
  logic sda;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;

  // wired-and with pull-up
  assign scl = (dev_scl_oe ? dev_scl_o : 1'b1) & (host_scl_oe ? host_scl_o : 1'b1);
  assign sda = (dev_sda_oe ? dev_sda_o : 1'b1) & (host_sda_oe ? host_sda_o : 1'b1);

  modport dev (
    input scl,
    input sda,
    output dev_scl_o,
    output dev_scl_oe,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    input scl,
    input sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface : irsp_link_if

`default_nettype wire

// file: logic/irsp_dev.sv
/*
  Two-wire slave port giving a bus master byte access to the module's
  registers and EEPROM. Assumes the register file answers rd_data
  combinationally from rd_addr, and takes writes on the wr_* handshake.
*/
// How it works
// - select pin low enables the two-wire port
// - busy pin output replaces serial-link role
// - accepts 100 kHz and 400 kHz bus clocks
// - acknowledge and act only on address match
// - address is 110100 plus select pin
// - first byte bit0: 1 read, 0 write
// - data changes only while clock low
// - sda fall/rise with clock high: start/stop
// - receiver pulls sda low to acknowledge
// - write: register address then data, msb first
// - one data byte, stored at stop if writable
// - hold clock low during EEPROM write time
// - master ends writes with stop after stretch
// - read continues on ack, stops on nack
// - read address wraps from 0F to 00
// - counter keeps next address, reads advance it
// - dummy write then repeated start for random
// - busy pin mirrors data-not-ready flag while port enabled, low otherwise
`default_nettype none

module irsp_dev #(
  parameter int unsigned EE_WRITE_CYCLES = irsp_pkg::EE_WRITE_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  irsp_link_if.dev link,
  input wire logic interface_select_pin,
  input wire logic address_select_pin,
  input wire logic busy_flag,
  output logic busy_pin,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);

  localparam int STRETCH_W = $clog2(EE_WRITE_CYCLES + 1);

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK,
    ST_IGNORE
  } irsp_dev_state_t;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] sel_sync;
  logic [1:0] cad_sync;
  logic scl_prev;
  logic sda_prev;

  // sampling at 250 MHz leaves ample margin at 400 kHz
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_sync <= {2{irsp_pkg::LINE_IDLE}};
      sda_sync <= {2{irsp_pkg::LINE_IDLE}};
      sel_sync <= {2{irsp_pkg::LINE_IDLE}};
      cad_sync <= 2'h0;
      scl_prev <= irsp_pkg::LINE_IDLE;
      sda_prev <= irsp_pkg::LINE_IDLE;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      sel_sync <= {sel_sync[0], interface_select_pin};
      cad_sync <= {cad_sync[0], address_select_pin};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic active;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;

  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign active = ~sel_sync[1];
  assign start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_cond = scl_s & scl_prev & ~sda_prev & sda_s;
  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;

  // ----------------------------------------------------------------------
  // busy indication
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_pin <= 1'b0;
    end else begin
      busy_pin <= active & busy_flag;
    end
  end

  // ----------------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] addr_next(input logic [7:0] a);
    return (a >= irsp_pkg::WRAP_ADDR) ? 8'h00 : a + 8'h01;
  endfunction : addr_next

  logic writable;
  logic ee_target;

  assign writable = (rd_addr[7:4] == 4'h0) & irsp_pkg::WRITABLE_MAP[rd_addr[3:0]];
  assign ee_target = (rd_addr[7:4] == 4'h0) & irsp_pkg::EEPROM_MAP[rd_addr[3:0]];

  // ----------------------------------------------------------------------
  // bus state machine
  // ----------------------------------------------------------------------
  irsp_dev_state_t state;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic got8;
  logic dir_read;
  logic [1:0] byte_idx;
  logic [7:0] pend_data;
  logic sda_oe;
  logic scl_oe;
  logic [STRETCH_W-1:0] stretch_cnt;
  logic buf_ready;
  logic push;

  // store happens only at stop, and never for a non-writable location
  assign push = active & stop_cond & (state != ST_IDLE) & ~dir_read
    & (byte_idx == 2'h2) & writable & buf_ready;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      got8 <= 1'b0;
      dir_read <= 1'b0;
      byte_idx <= 2'h0;
      pend_data <= 8'h00;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      stretch_cnt <= '0;
      rd_addr <= irsp_pkg::ADDR_RESET;
    end else if (!active) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      got8 <= 1'b0;
    end else if (start_cond) begin
      state <= ST_ADDR;
      bit_cnt <= 3'h0;
      got8 <= 1'b0;
      byte_idx <= 2'h0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      got8 <= 1'b0;
      if (push) begin
        rd_addr <= addr_next(rd_addr);
      end
    end else begin
      case (state)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 3'h1;
            got8 <= (bit_cnt == 3'h7);
          end
          // ack is driven only after the clock falls
          if (scl_fall && got8) begin
            got8 <= 1'b0;
            if (state == ST_ADDR) begin
              if (shreg[7:1] == {irsp_pkg::ADDR_HI, cad_sync[1]}) begin
                dir_read <= shreg[0];
                sda_oe <= 1'b1;
                state <= ST_ACK;
              end else begin
                state <= ST_IGNORE;
              end
            end else if (byte_idx == 2'h0) begin
              rd_addr <= shreg;
              byte_idx <= 2'h1;
              sda_oe <= 1'b1;
              state <= ST_ACK;
            end else if (byte_idx == 2'h1) begin
              pend_data <= shreg;
              byte_idx <= 2'h2;
              sda_oe <= 1'b1;
              state <= ST_ACK;
              if (ee_target) begin
                scl_oe <= 1'b1;
                stretch_cnt <= STRETCH_W'(EE_WRITE_CYCLES - 1);
              end else if (!buf_ready) begin
                scl_oe <= 1'b1;
                stretch_cnt <= '0;
              end
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_ACK: begin
          if (scl_oe) begin
            // also waits for buffer room so the stop never drops a word
            if (stretch_cnt != '0) begin
              stretch_cnt <= stretch_cnt - 1'b1;
            end else if (buf_ready) begin
              scl_oe <= 1'b0;
            end
          end else if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (dir_read) begin
              sda_oe <= ~rd_data[7];
              shreg <= {rd_data[6:0], 1'b1};
              rd_addr <= addr_next(rd_addr);
              state <= ST_TX;
            end else begin
              sda_oe <= 1'b0;
              state <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 3'h7) begin
              sda_oe <= 1'b0;
              state <= ST_MACK;
            end else begin
              sda_oe <= ~shreg[7];
              shreg <= {shreg[6:0], 1'b1};
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            state <= sda_s ? ST_IGNORE : ST_ACK;
          end
        end
        ST_IDLE, ST_IGNORE: begin
          sda_oe <= 1'b0;
          scl_oe <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.dev_scl_o = 1'b0;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_scl_oe = scl_oe;
  assign link.dev_sda_oe = sda_oe;

  // ----------------------------------------------------------------------
  // two-entry write buffer
  // ----------------------------------------------------------------------
  logic [1:0] buf_cnt;
  logic [15:0] buf_q0;
  logic [15:0] buf_q1;
  logic pop;

  assign buf_ready = (buf_cnt != 2'(irsp_pkg::BUF_DEPTH));
  assign wr_valid = (buf_cnt != 2'h0);
  assign pop = wr_valid & wr_ready;
  assign wr_addr = buf_q0[15:8];
  assign wr_data = buf_q0[7:0];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      buf_cnt <= 2'h0;
      buf_q0 <= 16'h0000;
      buf_q1 <= 16'h0000;
    end else begin
      if (push && (buf_cnt == 2'h0 || (buf_cnt == 2'h1 && pop))) begin
        buf_q0 <= {rd_addr, pend_data};
      end else if (push) begin
        buf_q1 <= {rd_addr, pend_data};
      end else if (pop && buf_cnt == 2'h2) begin
        buf_q0 <= buf_q1;
      end
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : irsp_dev

`default_nettype wire

// file: logic/irsp_host.sv
/*
  Bus master end of the two-wire link: single writes, current-address
  and random reads. Assumes the slave may stretch the clock; the
  master waits for the clock to rise before sampling.
*/
`default_nettype none

module irsp_host (
  input wire logic mclk,
  input wire logic resetn,
  irsp_link_if.host link,
  input wire logic fast_mode,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire irsp_pkg::irsp_op_t cmd_op,
  input wire logic cmd_addr_sel,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_wdata,
  input wire logic [4:0] cmd_count,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic done,
  output logic nack_err
);

  typedef enum {
    H_IDLE,
    H_START,
    H_ADDR,
    H_REG,
    H_DATA,
    H_RSTART,
    H_ADDR_R,
    H_READ,
    H_STOP
  } irsp_host_state_t;

  // ----------------------------------------------------------------------
  // line sync and quarter-bit divider
  // ----------------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [irsp_pkg::QTR_W-1:0] div_cnt;
  logic tick;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_sync <= {2{irsp_pkg::LINE_IDLE}};
      sda_sync <= {2{irsp_pkg::LINE_IDLE}};
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  assign tick = (div_cnt == '0);

  always_ff @(posedge mclk) begin
    if (!resetn || tick) begin
      div_cnt <= fast_mode ? irsp_pkg::QTR_W'(irsp_pkg::QTR_FAST_CYCLES - 1)
        : irsp_pkg::QTR_W'(irsp_pkg::QTR_STD_CYCLES - 1);
    end else begin
      div_cnt <= div_cnt - 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------------
  irsp_host_state_t step;
  logic [1:0] phase;
  logic [3:0] bit_idx;
  logic [7:0] tx;
  logic [7:0] rx;
  logic ack_bit;
  irsp_pkg::irsp_op_t op;
  logic sel;
  logic [7:0] reg_a;
  logic [7:0] wdata;
  logic [4:0] remain;
  logic scl_oe;
  logic sda_oe;
  logic adv;
  logic reading;

  // a stretched clock holds phase 2 until the line is seen high
  assign adv = tick & ~(phase == 2'h2 & ~scl_sync[1]);
  assign reading = (step == H_READ);
  assign cmd_ready = (step == H_IDLE);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      step <= H_IDLE;
      phase <= 2'h0;
      bit_idx <= 4'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      ack_bit <= 1'b1;
      op <= irsp_pkg::OP_WRITE;
      sel <= 1'b0;
      reg_a <= 8'h00;
      wdata <= 8'h00;
      remain <= 5'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      done <= 1'b0;
      nack_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      done <= 1'b0;
      nack_err <= 1'b0;
      if (step == H_IDLE) begin
        if (cmd_valid) begin
          op <= cmd_op;
          sel <= cmd_addr_sel;
          reg_a <= cmd_reg;
          wdata <= cmd_wdata;
          remain <= (cmd_count == 5'h00) ? 5'h01 : cmd_count;
          phase <= 2'h0;
          step <= H_START;
        end
      end else if (adv) begin
        phase <= phase + 2'h1;
        case (step)
          H_START, H_RSTART, H_STOP: begin
            case (phase)
              2'h0: begin
                scl_oe <= (step != H_START);
                sda_oe <= (step != H_RSTART);
              end
              2'h1: scl_oe <= 1'b0;
              // repeated start falls only once the clock is seen high
              2'h2: begin
                if (step == H_RSTART) begin
                  sda_oe <= 1'b1;
                end
              end
              2'h3: begin
                bit_idx <= 4'h0;
                scl_oe <= (step != H_STOP);
                sda_oe <= (step != H_STOP);
                if (step == H_STOP) begin
                  step <= H_IDLE;
                  done <= 1'b1;
                end else begin
                  tx <= {irsp_pkg::ADDR_HI, sel, (step == H_RSTART) | (op == irsp_pkg::OP_READ_CUR)};
                  step <= (step == H_START) ? H_ADDR : H_ADDR_R;
                end
              end
              default: ;
            endcase
          end
          H_ADDR, H_REG, H_DATA, H_ADDR_R, H_READ: begin
            case (phase)
              2'h0: begin
                scl_oe <= 1'b1;
                // data set up only with the clock held low
                if (bit_idx < 4'h8) begin
                  sda_oe <= ~reading & ~tx[7];
                  tx <= {tx[6:0], 1'b0};
                end else begin
                  sda_oe <= reading & (remain != 5'h01);
                end
              end
              2'h1: scl_oe <= 1'b0;
              2'h2: begin
                if (bit_idx < 4'h8) begin
                  rx <= {rx[6:0], sda_sync[1]};
                end else begin
                  ack_bit <= sda_sync[1];
                end
              end
              default: begin
                // clock falls a quarter before data may move
                scl_oe <= 1'b1;
                bit_idx <= (bit_idx == 4'h8) ? 4'h0 : bit_idx + 4'h1;
                if (bit_idx == 4'h8) begin
                  if (reading) begin
                    rx_valid <= 1'b1;
                    rx_data <= rx;
                    remain <= remain - 5'h01;
                    step <= (remain == 5'h01) ? H_STOP : H_READ;
                  end else if (ack_bit) begin
                    nack_err <= 1'b1;
                    step <= H_STOP;
                  end else if (step == H_ADDR) begin
                    tx <= reg_a;
                    step <= (op == irsp_pkg::OP_READ_CUR) ? H_READ : H_REG;
                  end else if (step == H_REG) begin
                    tx <= wdata;
                    step <= (op == irsp_pkg::OP_WRITE) ? H_DATA : H_RSTART;
                  end else if (step == H_DATA) begin
                    step <= H_STOP;
                  end else begin
                    step <= H_READ;
                  end
                end
              end
            endcase
          end
          default: step <= H_IDLE;
        endcase
      end
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
  assign link.host_scl_oe = scl_oe;
  assign link.host_sda_oe = sda_oe;

endmodule : irsp_host

`default_nettype wire

// file: testbench/irsp_link_sva.sv
/*
  Checker for the two-wire link between the slave port and the master end.
  Assumes it is instantiated beside the link interface with the same clock.
*/
`default_nettype none

module irsp_link_sva #(
  parameter int unsigned EE_WRITE_CYCLES = irsp_pkg::EE_WRITE_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_scl_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // stretch length counter
  // ----------------------------------------
  int unsigned stretch_cnt;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stretch_cnt <= 0;
    end else if (dev_scl_oe) begin
      stretch_cnt <= stretch_cnt + 1;
    end else begin
      stretch_cnt <= 0;
    end
  end

  // ----------------------------------------
  // link properties
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sda_moves_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device sda changed while scl high");
  hold_while_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device sda not held while scl high");
  drive_settle_a: assert property ($rose(dev_sda_oe) |-> (!scl) [*3])
    else $error("device sda driven too close to scl rise");
  drive_pulls_low_a: assert property (dev_sda_oe |-> !dev_sda_o && !sda)
    else $error("device drive does not pull sda low");
  stretch_in_low_a: assert property ($rose(dev_scl_oe) |-> !$past(scl) && dev_sda_oe)
    else $error("stretch began outside an acked low phase");
  stretch_len_a: assert property ($fell(dev_scl_oe) |-> stretch_cnt >= EE_WRITE_CYCLES)
    else $error("stretch shorter than write time");
  start_quiet_a: assert property ($fell(sda) && scl && $past(scl) |-> (!dev_sda_oe) [*8])
    else $error("device drives sda right after start");
  stop_release_a: assert property ($rose(sda) && scl && $past(scl) |=> (!dev_sda_oe && !dev_scl_oe) [*8])
    else $error("device holds a line after stop");
endmodule : irsp_link_sva

`default_nettype wire

// file: testbench/irsp_tb.sv
/*
  Self-checking bench: master end and slave port joined by the link.
  Assumes fast mode only, to keep the run short; register file is a
  combinational pattern of the address.
*/
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module irsp_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic interface_select_pin = 1'b0;
  logic address_select_pin = 1'b1;
  logic busy_flag = 1'b0;
  logic busy_pin;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_valid;
  logic wr_ready = 1'b0;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic fast_mode = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  irsp_pkg::irsp_op_t cmd_op = irsp_pkg::OP_WRITE;
  logic cmd_addr_sel = 1'b0;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [4:0] cmd_count = 5'h01;
  logic rx_valid;
  logic [7:0] rx_data;
  logic done;
  logic nack_err;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int nacks = 0;
  int stretched = 0;
  logic [7:0] rxq[$];

  always #2 mclk = ~mclk;
  // register file stand-in: value tied to address so order errors show
  assign rd_data = rd_addr ^ 8'h5A;

  irsp_link_if link();

  irsp_dev #(.EE_WRITE_CYCLES(20)) irsp_dev_inst (
    .mclk(mclk), .resetn(resetn), .link(link.dev),
    .interface_select_pin(interface_select_pin), .address_select_pin(address_select_pin),
    .busy_flag(busy_flag), .busy_pin(busy_pin), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));

  irsp_host irsp_host_inst (
    .mclk(mclk), .resetn(resetn), .link(link.host), .fast_mode(fast_mode),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr_sel(cmd_addr_sel),
    .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .cmd_count(cmd_count),
    .rx_valid(rx_valid), .rx_data(rx_data), .done(done), .nack_err(nack_err));

  irsp_link_sva #(.EE_WRITE_CYCLES(20)) irsp_link_sva_inst (
    .mclk(mclk), .resetn(resetn), .scl(link.scl), .sda(link.sda),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .dev_scl_oe(link.dev_scl_oe));

  // ----------------------------------------
  // monitor, timeout and close
  // ----------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
    end
    if (nack_err === 1'b1) begin
      nacks++;
    end
    if (link.dev_scl_oe === 1'b1) begin
      stretched++;
    end
    // scenarios take about 93k cycles
    if (cycles == 100000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  // one host command, held until taken, then wait for its end
  task automatic run(input irsp_pkg::irsp_op_t op, input logic sel, input logic [7:0] r,
                     input logic [7:0] w, input logic [4:0] n);
    int k;
    k = 0;
    cmd_op = op;
    cmd_addr_sel = sel;
    cmd_reg = r;
    cmd_wdata = w;
    cmd_count = n;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) step(1);
    step(1);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && k < 40000) begin
      step(1);
      k++;
    end
    `CHK(done, 1'b1)
    step(8);
  endtask : run

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    step(20);
    resetn = 1'b1;
    step(1);
    `CHK(busy_pin, 1'b0)
    `CHK(rd_addr, 8'h00)
    `CHK(wr_valid, 1'b0)
    `CHK(cmd_ready, 1'b1)
    busy_flag = 1'b1;
    step(4);
    `CHK(busy_pin, 1'b1)
    busy_flag = 1'b0;
    step(4);
    `CHK(busy_pin, 1'b0)
    // eeprom write with receiver stalled: entry must wait, stretch seen
    run(irsp_pkg::OP_WRITE, 1'b1, 8'h01, 8'hA5, 5'h01);
    `CHK(stretched, 20)
    `CHK(wr_valid, 1'b1)
    `CHK(wr_addr, 8'h01)
    `CHK(wr_data, 8'hA5)
    `CHK(rd_addr, 8'h02)
    // read-only target: nothing stored, head unchanged
    run(irsp_pkg::OP_WRITE, 1'b1, 8'h02, 8'h3C, 5'h01);
    `CHK(stretched, 20)
    `CHK(wr_addr, 8'h01)
    `CHK(wr_data, 8'hA5)
    wr_ready = 1'b1;
    step(2);
    `CHK(wr_valid, 1'b0)
    `CHK(nacks, 0)
    // random read across the wrap point
    rxq.delete();
    run(irsp_pkg::OP_READ_RAND, 1'b1, 8'h0F, 8'h00, 5'h02);
    `CHK(rxq.size(), 2)
    `CHK(rxq[0], 8'h0F ^ 8'h5A)
    `CHK(rxq[1], 8'h00 ^ 8'h5A)
    `CHK(rd_addr, 8'h01)
    // pin-selected address bit now 0: current read
    address_select_pin = 1'b0;
    step(4);
    rxq.delete();
    run(irsp_pkg::OP_READ_CUR, 1'b0, 8'h00, 8'h00, 5'h01);
    `CHK(rxq.size(), 1)
    `CHK(rxq[0], 8'h01 ^ 8'h5A)
    `CHK(rd_addr, 8'h02)
    `CHK(nacks, 0)
    // other address: ignored
    run(irsp_pkg::OP_WRITE, 1'b1, 8'h01, 8'h77, 5'h01);
    `CHK(nacks, 1)
    `CHK(wr_valid, 1'b0)
    `CHK(rd_addr, 8'h02)
    // port switched off: no answer, busy output gated
    interface_select_pin = 1'b1;
    busy_flag = 1'b1;
    step(4);
    `CHK(busy_pin, 1'b0)
    run(irsp_pkg::OP_READ_CUR, 1'b0, 8'h00, 8'h00, 5'h01);
    `CHK(nacks, 2)
    close_out();
  end
endmodule : irsp_tb

`undef CHK

`default_nettype wire
